// *** rtl/ufb_pkg.sv ***
package ufb_pkg;
  // register byte offsets
  localparam logic [7:0] A_CTRL  = 8'h00; // serial_control_reg
  localparam logic [7:0] A_DATA  = 8'h04; // tx write, rx read
  localparam logic [7:0] A_STAT  = 8'h08; // serial_status_reg
  localparam logic [7:0] A_MASK  = 8'h0C;
  localparam logic [7:0] A_POWER_CONTROL_REG  = 8'h10; // power_control_reg
  localparam logic [7:0] A_BRGH  = 8'h14; // baud_divisor_high
  localparam logic [7:0] A_BRGL  = 8'h18; // baud_divisor_low
  localparam logic [7:0] A_RCAUS = 8'h1C; // reset_cause_reg
  localparam logic [7:0] A_BOOT  = 8'h20; // boot_status_reg
  // serial_control_reg fields
  localparam int C_MSH = 7; // mode_select_high
  localparam int C_MSL = 6; // mode_select_low
  localparam int C_REN = 4; // receive enable
  localparam int C_TB8 = 3; // tx_ninth_bit
  localparam int C_RB8 = 2; // rx_ninth_bit
  // power_control_reg fields
  localparam int P_DBL = 7; // baud_double_select
  localparam int P_FER = 6; // framing_error_route
  localparam int P_BRK = 5; // break reset enable
  localparam int P_BRG = 0; // rate source: 1 baud generator
  // status and mask bits
  localparam int S_RX  = 0;
  localparam int S_TX  = 1;
  localparam int S_FE  = 2;
  localparam int S_BRK = 3;
  localparam int R_BRK = 0; // break flag in reset_cause_reg
  localparam int B_ST  = 0; // boot status bit
  // reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  POWER_CONTROL_REG_RST = 8'h00;
  localparam logic [15:0] BRG_RST  = 16'h0000;
  localparam logic [7:0]  BVEC_RST = 8'h00; // arbitrary value
  // timing: rate ticks per bit, sample point
  localparam logic [3:0] TPB_LAST = 4'hF;
  localparam logic [3:0] MID      = 4'h7;
  localparam logic [3:0] NB10     = 4'h9; // bits after start
  localparam logic [3:0] NB11     = 4'hA;
  typedef enum logic [1:0] {
    MD_SHIFT = 2'b00, MD_VAR10 = 2'b01,
    MD_FIX11 = 2'b10, MD_VAR11 = 2'b11
  } ufb_mode_type;
  typedef enum logic {TX_IDLE = 1'b0, TX_RUN = 1'b1} ufb_tx_type;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_BITS = 2'b10
  } ufb_rx_type;
endpackage : ufb_pkg

// *** rtl/ufb_top.sv ***
`timescale 1ns/1ns
module ufb_top (
  input  wire logic        pclk,    // oscillator clock
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cclk_en, // cpu clock enable pulse
  input  wire logic        t1_ovf,  // timer-1 overflow pulse
  input  wire logic        rxd,
  output logic             txd,
  output logic             irq,
  output logic             brk_rst, // device reset request
  output logic      [15:0] boot_addr
);
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  power_control_reg;
    logic [3:0]  mask;
    logic [3:0]  stat;
    logic [15:0] brg;
    logic [15:0] brg_cnt;
    logic        half;
    logic        t1half;
    logic        tick;
    ufb_pkg::ufb_tx_type tx_st;
    logic [10:0] tx_sh;
    logic [3:0]  tx_cnt;
    logic [3:0]  tx_bits;
    ufb_pkg::ufb_rx_type rx_st;
    logic [9:0]  rx_sh;
    logic [3:0]  rx_cnt;
    logic [3:0]  rx_bits;
    logic        rx_hi;
    logic [7:0]  rx_data;
    logic        rc_brk;
    logic        bstat;
    logic [7:0]  bvec;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        txd;
    logic        irq;
    logic        brk_rst;
    logic [15:0] boot_addr;
  } ufb_st_type;

  ufb_st_type q;
  ufb_st_type d;
  ufb_pkg::ufb_mode_type mode;
  logic eleven;
  logic access;
  logic rx_done;
  logic rx_stop;
  logic [31:0] rval;
  logic [3:0]  ev;      // status events raised this cycle

  assign mode   = ufb_pkg::ufb_mode_type'(q.ctrl[7:6]);
  assign eleven = q.ctrl[ufb_pkg::C_MSH];
  assign access = psel && penable && !q.pready;

  // read mux; bit 7 of control is routed error when enabled
  always_comb begin
    rval = 32'h0000_0000;
    case (paddr)
      ufb_pkg::A_CTRL: begin
        rval[7:0] = q.ctrl;
        if (q.power_control_reg[ufb_pkg::P_FER]) begin
          rval[7] = q.stat[ufb_pkg::S_FE];
        end
      end
      ufb_pkg::A_DATA:  rval[7:0] = q.rx_data;
      ufb_pkg::A_STAT:  rval[3:0] = q.stat;
      ufb_pkg::A_MASK:  rval[3:0] = q.mask;
      ufb_pkg::A_POWER_CONTROL_REG:  rval[7:0] = q.power_control_reg;
      ufb_pkg::A_BRGH:  rval[7:0] = q.brg[15:8];
      ufb_pkg::A_BRGL:  rval[7:0] = q.brg[7:0];
      ufb_pkg::A_RCAUS: rval[0]   = q.rc_brk;
      ufb_pkg::A_BOOT:  rval[15:0] = {q.bvec, 7'h00, q.bstat};
      default:          rval = 32'h0000_0000;
    endcase
  end

  // next state of the whole block
  always_comb begin
    d = q;
    rx_done = 1'b0;
    rx_stop = 1'b1;
    // events are kept apart so a status read cannot swallow them
    ev      = 4'h0;
    d.pready  = access;
    d.pslverr = 1'b0;
    d.tick    = 1'b0;
    d.brk_rst = 1'b0;
    // rate tick source, 16 ticks per bit
    if (mode == ufb_pkg::MD_FIX11) begin
      // cpu clock over 16 or 32
      if (cclk_en) begin
        d.half = !q.half;
        d.tick = q.power_control_reg[ufb_pkg::P_DBL] || q.half;
      end
    end else if (q.power_control_reg[ufb_pkg::P_BRG]) begin
      if (q.brg_cnt >= q.brg) begin
        d.brg_cnt = 16'h0000;
        d.tick = 1'b1;
      end else begin
        d.brg_cnt = q.brg_cnt + 16'h0001;
      end
    end else if (t1_ovf) begin
      // timer-1 halved when doubling bit set
      d.t1half = !q.t1half;
      d.tick = !q.power_control_reg[ufb_pkg::P_DBL] || q.t1half;
    end
    // variable modes share the timer or generator path
    // variable 11-bit differs only in this rate

    // transmitter; shift out LSB first
    if (q.tx_st == ufb_pkg::TX_RUN && q.tick) begin
      d.tx_cnt = q.tx_cnt + 4'h1;
      if (q.tx_cnt == ufb_pkg::TPB_LAST) begin
        d.tx_sh = {1'b1, q.tx_sh[10:1]};
        if (q.tx_bits == 4'h0) begin
          d.tx_st = ufb_pkg::TX_IDLE;
          d.stat[ufb_pkg::S_TX] = 1'b1;
          ev[ufb_pkg::S_TX] = 1'b1;
        end else begin
          d.tx_bits = q.tx_bits - 4'h1;
        end
      end
    end

    // receiver
    case (q.rx_st)
      ufb_pkg::RX_IDLE: begin
        if (q.ctrl[ufb_pkg::C_REN] && q.tick && !rxd) begin
          d.rx_st  = ufb_pkg::RX_START;
          d.rx_cnt = 4'h0;
        end
      end
      ufb_pkg::RX_START: begin
        if (q.tick) begin
          d.rx_cnt = q.rx_cnt + 4'h1;
          if (q.rx_cnt == ufb_pkg::MID) begin
            // a high midpoint is a glitch, not a start
            d.rx_st   = rxd ? ufb_pkg::RX_IDLE : ufb_pkg::RX_BITS;
            d.rx_cnt  = 4'h0;
            d.rx_bits = 4'h0;
            d.rx_hi   = 1'b0;
          end
        end
      end
      ufb_pkg::RX_BITS: begin
        if (q.tick) begin
          d.rx_cnt = q.rx_cnt + 4'h1;
          if (q.rx_cnt == ufb_pkg::TPB_LAST) begin
            d.rx_sh   = {rxd, q.rx_sh[9:1]};
            d.rx_hi   = q.rx_hi || rxd;
            d.rx_bits = q.rx_bits + 4'h1;
            if (q.rx_bits + 4'h1 == (eleven ? ufb_pkg::NB11
                                             : ufb_pkg::NB10)) begin
              rx_done = 1'b1;
              rx_stop = rxd;
              d.rx_st = ufb_pkg::RX_IDLE;
            end
          end
        end
      end
      default: d.rx_st = ufb_pkg::RX_IDLE;
    endcase

    if (rx_done) begin
      d.stat[ufb_pkg::S_RX] = 1'b1;
      ev[ufb_pkg::S_RX] = 1'b1;
      if (eleven) begin
        // keep ninth bit, stop bit dropped
        d.rx_data = d.rx_sh[7:0];
        d.ctrl[ufb_pkg::C_RB8] = d.rx_sh[8];
      end else begin
        d.rx_data = d.rx_sh[8:1];
        d.ctrl[ufb_pkg::C_RB8] = rxd;
      end
      if (!rx_stop) begin
        d.stat[ufb_pkg::S_FE] = 1'b1;
        ev[ufb_pkg::S_FE] = 1'b1;
        // low across the whole frame is a break
        if (!d.rx_hi) begin
          d.stat[ufb_pkg::S_BRK] = 1'b1;
          ev[ufb_pkg::S_BRK] = 1'b1;
          if (q.power_control_reg[ufb_pkg::P_BRK]) begin
            d.rc_brk  = 1'b1;
            d.brk_rst = 1'b1;
          end
        end
      end
    end

    // register access; events already applied, so a status read keeps them but writing 0 to reset cause clears a new break
    if (access) begin
      d.prdata = rval;
      if (pwrite) begin
        case (paddr)
          ufb_pkg::A_CTRL: begin
            // mode high bit frozen while route set
            d.ctrl[6:3] = pwdata[6:3];
            if (!q.power_control_reg[ufb_pkg::P_FER]) begin
              d.ctrl[7] = pwdata[7];
            end
          end
          ufb_pkg::A_DATA: begin
            // writes while busy are dropped
            if (q.tx_st == ufb_pkg::TX_IDLE) begin
              d.tx_st  = ufb_pkg::TX_RUN;
              d.tx_cnt = 4'h0;
              if (eleven) begin
                d.tx_sh = {1'b1, q.ctrl[ufb_pkg::C_TB8],
                           pwdata[7:0], 1'b0};
                d.tx_bits = ufb_pkg::NB11;
              end else begin
                d.tx_sh = {2'b11, pwdata[7:0], 1'b0};
                d.tx_bits = ufb_pkg::NB10;
              end
            end
          end
          ufb_pkg::A_MASK:  d.mask = pwdata[3:0];
          ufb_pkg::A_POWER_CONTROL_REG:  d.power_control_reg = pwdata[7:0];
          ufb_pkg::A_BRGH:  d.brg[15:8] = pwdata[7:0];
          ufb_pkg::A_BRGL:  d.brg[7:0] = pwdata[7:0];
          ufb_pkg::A_RCAUS: d.rc_brk = d.rc_brk && pwdata[0];
          ufb_pkg::A_BOOT: begin
            d.bstat = pwdata[0];
            d.bvec  = pwdata[15:8];
          end
          ufb_pkg::A_STAT: d.pslverr = 1'b0;
          default:         d.pslverr = 1'b1;
        endcase
      end else begin
        // read clears status, but a new event wins
        if (paddr == ufb_pkg::A_STAT) begin
          d.stat = ev;
        end
        if (paddr > ufb_pkg::A_BOOT || paddr[1:0] != 2'b00) begin
          d.pslverr = 1'b1;
        end
      end
      if (paddr > ufb_pkg::A_BOOT || paddr[1:0] != 2'b00) begin
        d.pslverr = 1'b1;
      end
    end

    d.txd = (d.tx_st == ufb_pkg::TX_RUN) ? d.tx_sh[0] : 1'b1;
    d.irq = |(d.stat & d.mask);
    // break cause selects boot vector page
    d.boot_addr = (d.rc_brk || d.bstat) ? {d.bvec, 8'h00}
                                        : 16'h0000;
  end

  // the single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.ctrl  <= ufb_pkg::CTRL_RST;
      q.power_control_reg  <= ufb_pkg::POWER_CONTROL_REG_RST;
      q.brg   <= ufb_pkg::BRG_RST;
      q.bvec  <= ufb_pkg::BVEC_RST;
      q.tx_st <= ufb_pkg::TX_IDLE;
      q.rx_st <= ufb_pkg::RX_IDLE;
      q.txd   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata    = q.prdata;
  assign pready    = q.pready;
  assign pslverr   = q.pslverr;
  assign txd       = q.txd;
  assign irq       = q.irq;
  assign brk_rst   = q.brk_rst;
  assign boot_addr = q.boot_addr;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_tx_load;
    $past(q.tx_st) == ufb_pkg::TX_IDLE && q.tx_st == ufb_pkg::TX_RUN;
  endsequence
  sequence s_ten_done;
    rx_done && !eleven;
  endsequence
  sequence s_low_frame;
    rx_done && !rxd && !q.rx_hi;
  endsequence
  sequence s_ctrl_read;
    access && !pwrite && paddr == ufb_pkg::A_CTRL;
  endsequence

  tx_start_low_a: assert property (s_tx_load |-> !txd)
    else $error("start bit not low");
  tx_ninth_a: assert property (
    s_tx_load ##0 eleven |-> q.tx_sh[9] == q.ctrl[ufb_pkg::C_TB8])
    else $error("ninth bit not from tx_ninth_bit");
  rx_stop_rb8_a: assert property (
    s_ten_done |=> q.ctrl[ufb_pkg::C_RB8] == $past(rxd))
    else $error("stop bit not stored");
  rx_ninth_a: assert property (
    rx_done && eleven |=> q.ctrl[ufb_pkg::C_RB8] == $past(q.rx_sh[9]))
    else $error("ninth bit not stored");
  fix_rate_a: assert property (
    mode == ufb_pkg::MD_FIX11 && q.power_control_reg[ufb_pkg::P_DBL] && cclk_en
    |=> q.tick)
    else $error("fixed rate not sixteenth");
  t1_half_a: assert property (
    mode != ufb_pkg::MD_FIX11 && !q.power_control_reg[ufb_pkg::P_BRG]
    && q.power_control_reg[ufb_pkg::P_DBL] && t1_ovf && !q.t1half |=> !q.tick)
    else $error("timer rate not halved");
  brg_tick_a: assert property (
    mode != ufb_pkg::MD_FIX11 && q.power_control_reg[ufb_pkg::P_BRG]
    && q.brg_cnt == q.brg |=> q.tick && q.brg_cnt == 16'h0000)
    else $error("divisor tick missing");
  fe_flag_a: assert property (rx_done && !rxd |=> q.stat[2])
    else $error("framing error lost");
  brk_reset_a: assert property (
    brk_rst |-> q.rc_brk ##1 !brk_rst)
    else $error("break reset not flagged");
  boot_addr_a: assert property (
    brk_rst |-> boot_addr == {q.bvec, 8'h00})
    else $error("boot address wrong");
  brk_flag_a: assert property (
    s_low_frame |=> q.stat[ufb_pkg::S_BRK])
    else $error("break not flagged");
  fe_route_a: assert property (
    s_ctrl_read ##0 q.power_control_reg[ufb_pkg::P_FER]
    |=> prdata[7] == $past(q.stat[ufb_pkg::S_FE]))
    else $error("routed error bit wrong");
  tx_stop_high_a: assert property (
    q.tx_st == ufb_pkg::TX_RUN && q.tx_bits == 4'h0 |-> txd)
    else $error("stop bit not high");
  fix_rate32_a: assert property (
    mode == ufb_pkg::MD_FIX11 && !q.power_control_reg[ufb_pkg::P_DBL] && cclk_en
    && !q.half |=> !q.tick)
    else $error("fixed rate not thirty-second");
  rx_flag_a: assert property (
    rx_done |=> q.stat[ufb_pkg::S_RX])
    else $error("receive flag lost");
endmodule // ufb_top

// *** bench/ufb_remote.sv ***
`timescale 1ns/1ns
// far side serial partner; line idles high between frames
module ufb_remote (
  input  wire logic pclk,
  input  wire logic txd,
  output logic      rxd
);
  initial rxd = 1'b1;
  task automatic send(input logic [10:0] bits, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (per) @(posedge pclk);
    end
    rxd <= 1'b1;
  endtask
  // sample mid bit, bounded wait for start edge
  task automatic recv(output logic [10:0] bits, output logic ok,
                      input int n, input int per);
    int t;
    bits = '0;
    t = 0;
    while (txd !== 1'b0 && t < 4000) begin
      @(posedge pclk);
      t++;
    end
    ok = (t < 4000);
    repeat (per / 2) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd;
      repeat (per) @(posedge pclk);
    end
  endtask
endmodule // ufb_remote

// *** bench/tb.sv ***
`timescale 1ns/1ns
module tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, st;
  logic        pready, pslverr, se, txd, rxd, irq, brk_rst, ok;
  logic        cclk_en = 0, t1_ovf = 0, brk_seen = 0, tb8, b9;
  logic [15:0] boot_addr;
  logic [10:0] got, fr;
  logic [7:0]  d;
  logic [1:0]  md;
  int          errors = 0, n_tests = 0, n, p;
  // rate configs: mode, power control, pclk per bit
  logic [1:0]  mds [6] = '{2'b01, 2'b01, 2'b01, 2'b10, 2'b10, 2'b11};
  logic [7:0]  pcs [6] = '{8'h01, 8'h00, 8'h80, 8'h80, 8'h00, 8'h01};
  int          pers [6] = '{32, 32, 64, 32, 64, 32};
  ufb_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cclk_en, .t1_ovf, .rxd, .txd, .irq,
    .brk_rst, .boot_addr);
  ufb_remote far (.pclk, .txd, .rxd);
  always #25 pclk = ~pclk;
  // cpu clock enable and timer overflow every second pclk
  always @(posedge pclk) begin
    cclk_en <= ~cclk_en;
    t1_ovf  <= ~t1_ovf;
    if (brk_rst === 1'b1) brk_seen <= 1'b1;
  end
  task automatic final_report;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // apb master: hold request until pready sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // pready is read as it stood at this rising edge
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) begin
      errors++;
      final_report();
    end else begin
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask
  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // poll status until a bit shows; reads clear it
  task automatic wait_stat(input int b);
    st = '0;
    for (int i = 0; i < 300 && st[b] !== 1'b1; i++) begin
      rdr(ufb_pkg::A_STAT);
      st = st | rd;
    end
    if (st[b] !== 1'b1) begin
      errors++;
      final_report();
    end
  endtask
  initial begin
    void'($urandom(91));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdr(ufb_pkg::A_CTRL);
    chk(rd, {24'h0, ufb_pkg::CTRL_RST});
    rdr(ufb_pkg::A_POWER_CONTROL_REG);
    chk(rd, {24'h0, ufb_pkg::POWER_CONTROL_REG_RST});
    rdr(8'h24);
    chk({rd[30:0], se}, 32'h1);
    // generator tick every divisor+1 pclk, 32 pclk per bit
    wr(ufb_pkg::A_BRGH, 32'h0);
    wr(ufb_pkg::A_BRGL, 32'h1);
    for (int i = 0; i < 6; i++) begin
      md = mds[i];
      p = pers[i];
      n = md[1] ? 11 : 10;
      tb8 = ~i[0];
      b9 = i[0];
      d = 8'($urandom);
      wr(ufb_pkg::A_POWER_CONTROL_REG, {24'h0, pcs[i]});
      wr(ufb_pkg::A_CTRL, {24'h0, md, 2'b01, tb8, 3'b000});
      wr(ufb_pkg::A_MASK, 32'h1);
      fork
        wr(ufb_pkg::A_DATA, {24'h0, d});
        far.recv(got, ok, n, p);
      join
      chk(ok, 1'b1);
      if (ok !== 1'b1) final_report();
      fr = md[1] ? {1'b1, tb8, d, 1'b0} : {2'b01, d, 1'b0};
      chk(got, fr);
      d = 8'($urandom);
      fr = md[1] ? {1'b1, b9, d, 1'b0} : {2'b01, d, 1'b0};
      far.send(fr, n, p);
      chk(irq, 1'b1);
      wait_stat(ufb_pkg::S_RX);
      rdr(ufb_pkg::A_DATA);
      chk(rd[7:0], d);
      rdr(ufb_pkg::A_CTRL);
      chk(rd[ufb_pkg::C_RB8], md[1] ? b9 : 1'b1);
      chk(irq, 1'b0);
    end
    // framing error seen in status and on control bit 7
    wr(ufb_pkg::A_POWER_CONTROL_REG, 32'h01);
    wr(ufb_pkg::A_CTRL, 32'h50);
    wr(ufb_pkg::A_MASK, 32'h1 << ufb_pkg::S_FE);
    wr(ufb_pkg::A_POWER_CONTROL_REG, 32'h41);
    far.send(11'h0A6, 10, 32);
    chk(irq, 1'b1);
    rdr(ufb_pkg::A_CTRL);
    chk(rd[7], 1'b1);
    wait_stat(ufb_pkg::S_FE);
    chk(st[ufb_pkg::S_FE], 1'b1);
    wr(ufb_pkg::A_POWER_CONTROL_REG, 32'h01);
    rdr(ufb_pkg::A_CTRL);
    chk(rd[7], 1'b0);
    // break: whole frame low, stop included
    wr(ufb_pkg::A_BOOT, 32'h3C00);
    chk(boot_addr, 16'h0000);
    wr(ufb_pkg::A_POWER_CONTROL_REG, 32'h21);
    far.send(11'h000, 10, 32);
    repeat (40) @(posedge pclk);
    chk(brk_seen, 1'b1);
    rdr(ufb_pkg::A_RCAUS);
    chk(rd[ufb_pkg::R_BRK], 1'b1);
    chk(boot_addr, 16'h3C00);
    wr(ufb_pkg::A_RCAUS, 32'h0);
    chk(boot_addr, 16'h0000);
    rdr(ufb_pkg::A_RCAUS);
    chk(rd[ufb_pkg::R_BRK], 1'b0);
    final_report();
  end
endmodule // tb
